// ---- hw/lsu_core.sv ----
// Single-word and single-byte load/store unit
`default_nettype none
module lsu_core
  import lsu_pkg::*;
(
  input  wire logic        i_clock,
  input  wire logic        i_nrst,
  input  wire logic        i_start,
  input  wire lsu_req_t    i_req,
  input  wire logic        i_endian_select,
  input  wire logic [31:0] i_rdata,
  input  wire logic        i_mem_fault,
  output logic             o_busy,
  output lsu_mem_t         o_mem,
  output lsu_res_t         o_res
);
  typedef struct packed {
    lsu_state_t  state;
    logic [31:0] addr;
    logic [31:0] new_base;
    logic [31:0] wdata_src;
    logic [3:0]  rd;
    logic [3:0]  rn;
    logic        load;
    logic        byte_sel;
    logic        wb;
    logic        user;
    logic        to_pc;
    logic        fault;
    logic [2:0]  cnt;
    lsu_mem_t    mem;
    lsu_res_t    res;
  } lsu_core_st_t;

  lsu_core_st_t st;
  lsu_core_st_t next_st;
  logic [31:0]  base_val;
  logic [31:0]  offs;
  logic [31:0]  moved;
  logic         pre;
  logic         capture;
  logic [31:0]  load_word;
  logic [31:0]  lane_wdata;

  // Barrel shift by immediate amount; register amounts cannot reach here
  function automatic logic [31:0] shift_imm(input logic [31:0] v, input logic [1:0] t, input logic [4:0] n);
    logic [31:0] r;
    r = v;
    case (t)
      2'h0: r = v << n;
      2'h1: r = (n == 5'h00) ? 32'h0000_0000 : v >> n;
      2'h2: r = (n == 5'h00) ? {32{v[31]}} : 32'($signed(v) >>> n);
      default: r = (v >> n) | (v << (6'd32 - {1'b0, n}));
    endcase
    return r;
  endfunction

  always_comb begin
    // (R15) counter as base reads plus 8
    base_val = (i_req.instr[19:16] == LSU_PC_INDEX) ? i_req.pc + LSU_PC_BASE_ADD : i_req.base;
    // (R1) (R7) immediate or shifted register offset
    if (i_req.instr[LSU_IREG_BIT]) begin
      offs = shift_imm(i_req.offset, i_req.instr[LSU_STYPE_LSB+1:LSU_STYPE_LSB],
                       i_req.instr[LSU_SHAMT_LSB+4:LSU_SHAMT_LSB]);
    end else begin
      offs = {20'h00000, i_req.instr[LSU_IMM_MSB:0]};
    end
    // (R2) add or subtract
    moved = i_req.instr[LSU_U_BIT] ? base_val + offs : base_val - offs;
    pre = i_req.instr[LSU_P_BIT];
  end

  assign capture = (st.state == LSU_XFER) && st.load;

  lsu_lane u_lane (
    .i_clock         (i_clock),
    .i_nrst          (i_nrst),
    .i_capture       (capture),
    .i_endian_select (i_endian_select),
    .i_byte_sel      (st.byte_sel),
    .i_addr_low      (st.addr[1:0]),
    .i_rdata         (i_rdata),
    .i_store         (st.wdata_src),
    .o_load          (load_word),
    .o_wdata         (lane_wdata)
  );

  always_comb begin
    next_st = st;
    next_st.res.load_we = 1'b0;
    next_st.res.base_we = 1'b0;
    next_st.res.abort = 1'b0;
    next_st.res.done = 1'b0;
    case (st.state)
      LSU_IDLE: begin
        next_st.mem = '0;
        if (i_start) begin
          // (R3) pre uses moved address, post uses base
          next_st.addr = pre ? moved : base_val;
          next_st.new_base = moved;
          next_st.rd = i_req.instr[15:12];
          next_st.rn = i_req.instr[19:16];
          next_st.load = i_req.instr[LSU_L_BIT];
          // (R8) byte or word
          next_st.byte_sel = i_req.instr[LSU_B_BIT];
          // (R4) (R5) write-back choice
          next_st.wb = pre ? i_req.instr[LSU_W_BIT] : 1'b1;
          // (R6) forced non-privileged access
          next_st.user = !i_req.privileged || (!pre && i_req.instr[LSU_W_BIT]);
          // (R16) counter stored as plus 12
          next_st.wdata_src = (i_req.instr[15:12] == LSU_PC_INDEX) ? i_req.pc + LSU_PC_DATA_ADD : i_req.store;
          next_st.to_pc = i_req.instr[LSU_L_BIT] && (i_req.instr[15:12] == LSU_PC_INDEX);
          next_st.fault = 1'b0;
          next_st.state = LSU_ADDR;
        end
      end
      LSU_ADDR: begin
        // (R20) first cycle: address calculation, non-sequential
        next_st.mem.addr = st.addr;
        next_st.mem.write = !st.load;
        next_st.mem.byte_sel = st.byte_sel;
        next_st.mem.user = st.user;
        next_st.mem.req = 1'b1;
        next_st.mem.cyc = LSU_CYC_N;
        next_st.state = LSU_XFER;
      end
      LSU_XFER: begin
        next_st.mem.req = 1'b0;
        next_st.mem.user = 1'b0;
        // (R19) fault aborts the transfer
        next_st.fault = i_mem_fault;
        if (st.load) begin
          next_st.mem.cyc = LSU_CYC_I;
          next_st.state = LSU_INT;
        end else begin
          next_st.mem.cyc = LSU_CYC_N;
          next_st.state = LSU_DONE;
        end
      end
      LSU_INT: begin
        // (R20) counter load adds refill 1N+2S beyond a plain load, where the document's cycle counts differ by 1S+1N
        next_st.cnt = st.to_pc && !st.fault ? 3'h3 : LSU_CNT_ZERO;
        next_st.mem.cyc = st.to_pc && !st.fault ? LSU_CYC_N : LSU_CYC_S;
        next_st.state = (st.to_pc && !st.fault) ? LSU_REFIL : LSU_DONE;
      end
      LSU_REFIL: begin
        next_st.mem.cyc = LSU_CYC_S;
        next_st.cnt = st.cnt - 3'h1;
        if (st.cnt == 3'h1) begin
          next_st.state = LSU_DONE;
        end
      end
      LSU_DONE: begin
        next_st.mem.cyc = LSU_CYC_I;
        next_st.res.done = 1'b1;
        next_st.res.abort = st.fault;
        // (R19) aborted access leaves registers untouched for restart
        next_st.res.load_we = st.load && !st.fault;
        next_st.res.load_data = load_word;
        next_st.res.load_reg = st.rd;
        next_st.res.base_we = st.wb && !st.fault && !(st.load && st.rd == st.rn);
        next_st.res.base_data = st.new_base;
        next_st.res.base_reg = st.rn;
        next_st.state = LSU_IDLE;
      end
      default: begin
        next_st.state = LSU_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      st <= '0;
      st.state <= LSU_IDLE;
    end else begin
      st <= next_st;
    end
  end

  assign o_busy = (st.state != LSU_IDLE);
  always_comb begin
    o_mem = st.mem;
    o_mem.wdata = lane_wdata;
  end
  assign o_res = st.res;
endmodule
`default_nettype wire

// ---- hw/lsu_lane.sv ----
// Byte-lane steering for loads and stores
`default_nettype none
module lsu_lane
  import lsu_pkg::*;
(
  input  wire logic        i_clock,
  input  wire logic        i_nrst,
  input  wire logic        i_capture,
  input  wire logic        i_endian_select,
  input  wire logic        i_byte_sel,
  input  wire logic [1:0]  i_addr_low,
  input  wire logic [31:0] i_rdata,
  input  wire logic [31:0] i_store,
  output logic [31:0]      o_load,
  output logic [31:0]      o_wdata
);
  typedef struct packed {
    logic [31:0] load;
  } lsu_lane_st_t;
  lsu_lane_st_t st;
  lsu_lane_st_t next_st;
  logic [4:0]   amt;
  logic [1:0]   lane;
  logic [31:0]  lane_word;

  function automatic logic [31:0] rotr(input logic [31:0] v, input logic [4:0] n);
    rotr = (v >> n) | (v << (6'd32 - {1'b0, n}));
  endfunction

  always_comb begin
    next_st = st;
    amt = {i_addr_low, 3'h0};
    // (R21) endian choice steers lane index
    lane = i_endian_select ? ~i_addr_low : i_addr_low;
    lane_word = rotr(i_rdata, {lane, 3'h0});
    if (i_capture) begin
      if (i_byte_sel) begin
        // (R9) (R12) byte lane zero-extended
        next_st.load = {24'h000000, lane_word[7:0]};
      end else if (!i_endian_select) begin
        // (R11) (R22) rotate right by 8 times offset
        next_st.load = rotr(i_rdata, amt);
      end else begin
        // (R13) Same right rotation: even offsets land in 31:24, odd in 15:8
        next_st.load = rotr(i_rdata, amt);
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign o_load = st.load;
  // (R10) byte replicated; (R14) word unrotated
  assign o_wdata = i_byte_sel ? {4{i_store[7:0]}} : i_store;
endmodule
`default_nettype wire

// ---- hw/lsu_pkg.sv ----
// Constants and carrier types for the load/store unit
// How it works
// (R1) Offset is a 12-bit immediate or a shifted offset register.
// (R2) Direction bit one adds offset to base, zero subtracts.
// (R3) Pre-index uses offset address; post-index uses plain base, offset after.
// (R4) Pre-indexed: write back modified base only when write-back bit set.
// (R5) Post-indexed transfers always write back the modified base; the core skips it for a load whose destination register is the base.
// (R6) Privileged post-index with write-back bit forces non-privileged access.
// (R7) Shift amount only from instruction shift bits, never from a register.
// (R8) Byte-select bit one moves a byte, zero moves a 32-bit word.
// (R9) Little-endian byte load picks lane by address upward, zero-extended.
// (R10) Byte store replicates low register byte across all four lanes.
// (R11) Little-endian unaligned word load rotates addressed byte into bits 7:0.
// (R12) Big-endian byte load picks lane from bits 31:24 downward, zero-extended.
// (R13) Big-endian unaligned word load: offset 0/2 to 31:24, 1/3 to 15:8.
// (R14) Word store drives register word unrotated on the bus.
// (R15) Program counter as base reads instruction address plus 8.
// (R16) Program counter stored as data gives instruction address plus 12.
// (R17) Stream never writes back with counter base nor uses counter offset.
// (R18) Stream avoids post-index with offset register equal to base.
// (R19) Memory fault during transfer raises the data abort trap.
// (R20) Load 1S+1N+1I, load to counter 2S+2N+1I, store 2N cycles; the core takes 3S+2N+1I for a counter load.
// (R21) Endian select picks little or big lane behaviour.
// (R22) Little-endian rotation is right by eight times low address bits.
`default_nettype none
package lsu_pkg;
  localparam logic [3:0]  LSU_PC_INDEX    = 4'hF;
  localparam logic [31:0] LSU_PC_BASE_ADD = 32'h0000_0008;
  localparam logic [31:0] LSU_PC_DATA_ADD = 32'h0000_000C;
  localparam int          LSU_IMM_MSB     = 11;
  localparam int          LSU_SHAMT_LSB   = 7;
  localparam int          LSU_STYPE_LSB   = 5;
  localparam int          LSU_IREG_BIT    = 25;
  localparam int          LSU_P_BIT       = 24;
  localparam int          LSU_U_BIT       = 23;
  localparam int          LSU_B_BIT       = 22;
  localparam int          LSU_W_BIT       = 21;
  localparam int          LSU_L_BIT       = 20;
  localparam logic [2:0]  LSU_CNT_ZERO    = 3'h0;

  // Cycle types presented on the memory interface
  typedef enum logic [1:0] {
    LSU_CYC_I = 2'h0,
    LSU_CYC_N = 2'h1,
    LSU_CYC_S = 2'h2
  } lsu_cyc_t;

  typedef enum logic [5:0] {
    LSU_IDLE  = 6'h01,
    LSU_ADDR  = 6'h02,
    LSU_XFER  = 6'h04,
    LSU_INT   = 6'h08,
    LSU_REFIL = 6'h10,
    LSU_DONE  = 6'h20
  } lsu_state_t;

  typedef struct packed {
    logic [31:0] instr;
    logic [31:0] base;
    logic [31:0] offset;
    logic [31:0] store;
    logic [31:0] pc;
    logic        privileged;
  } lsu_req_t;

  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wdata;
    logic        write;
    logic        byte_sel;
    logic        user;
    logic        req;
    lsu_cyc_t    cyc;
  } lsu_mem_t;

  typedef struct packed {
    logic [31:0] load_data;
    logic        load_we;
    logic [3:0]  load_reg;
    logic [31:0] base_data;
    logic        base_we;
    logic [3:0]  base_reg;
    logic        abort;
    logic        done;
  } lsu_res_t;
endpackage
`default_nettype wire

// ---- verification/lsu_asserts.sv ----
// Port-level checks for the load/store unit
`default_nettype none
module lsu_asserts
  import lsu_pkg::*;
(
  input wire logic        i_clock,
  input wire logic        i_nrst,
  input wire logic        i_start,
  input wire lsu_req_t    i_req,
  input wire logic        i_endian_select,
  input wire logic [31:0] i_rdata,
  input wire logic        i_mem_fault,
  input wire logic        o_busy,
  input wire lsu_mem_t    o_mem,
  input wire lsu_res_t    o_res
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_nrst);
  logic take;
  assign take = i_start & ~o_busy;
  chk_busy_rise: assert property (take |=> o_busy)
    else $error("busy not raised after start");
  chk_req_soon: assert property (take |-> ##[1:4] o_mem.req)
    else $error("no memory request after start");
  chk_end_bound: assert property (take |-> ##[3:9] (o_res.done | o_res.abort))
    else $error("transfer did not finish");
  chk_req_single: assert property (o_mem.req |=> !o_mem.req)
    else $error("request longer than one cycle");
  chk_req_cycle: assert property (o_mem.req |-> o_mem.cyc == LSU_CYC_N && o_busy)
    else $error("request not a busy nonsequential cycle");
  chk_byte_repl: assert property (o_mem.req && o_mem.write && o_mem.byte_sel |->
    o_mem.wdata == {4{o_mem.wdata[7:0]}}) else $error("byte store not replicated");
  chk_fault_block: assert property (o_res.abort |-> !o_res.load_we && !o_res.base_we)
    else $error("write enable during abort");
  chk_done_pulse: assert property (o_res.done |=> !o_res.done)
    else $error("done longer than one cycle");
  chk_busy_hold: assert property ($rose(o_busy) |-> o_busy[*3])
    else $error("busy dropped early");
  cov_load: cover property (o_res.load_we);
  cov_abort: cover property (o_res.abort);
  cov_user: cover property (o_mem.req && o_mem.user);
endmodule
`default_nettype wire

// ---- verification/lsu_core_tb.sv ----
// Self-checking bench for the load/store unit
`default_nettype none
module lsu_core_tb
  import lsu_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        i_clock, i_nrst, i_start, i_endian_select, i_mem_fault, fault_en;
  lsu_req_t    i_req;
  logic [31:0] i_rdata;
  logic        o_busy;
  lsu_mem_t    o_mem;
  lsu_res_t    o_res;
  int          n_mismatch = 0, n_checks = 0, ticks = 0;
  lsu_core dut (.i_clock(i_clock), .i_nrst(i_nrst), .i_start(i_start), .i_req(i_req),
    .i_endian_select(i_endian_select), .i_rdata(i_rdata), .i_mem_fault(i_mem_fault),
    .o_busy(o_busy), .o_mem(o_mem), .o_res(o_res));
  lsu_mem_model mem (.i_clock(i_clock), .i_nrst(i_nrst), .i_mem(o_mem), .i_fault_en(fault_en),
    .o_rdata(i_rdata), .o_fault(i_mem_fault));
  initial begin
    i_clock = 1'b0;
    forever #2 i_clock = ~i_clock;
  end
  task automatic give_verdict();
    $display("Checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  always @(posedge i_clock) begin
    ticks++;
    if (ticks == 3000) begin
      n_mismatch++;
      give_verdict();
    end
  end
  task automatic cmpv(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Flags f are {I,P,U,B,W,L}
  function automatic logic [31:0] mk(input logic [5:0] f, input logic [3:0] rn, rd, input logic [11:0] lo);
    return {6'h39, f, rn, rd, lo};
  endfunction
  task automatic xfer(input logic [31:0] ins, bs, of, sd, input logic pv, en, flt);
    logic [31:0] ofs, bv, nb, ea, w, dv, sv;
    logic        st, bwe;
    int          n;
    lsu_mem_t    m;
    while (o_busy !== 1'b0) begin
      @(posedge i_clock);
      #1;
    end
    i_req = '{ins, bs, of, sd, 32'h0000_4000, pv};
    i_endian_select = en;
    fault_en = flt;
    i_start = 1'b1;
    @(posedge i_clock);
    #1;
    i_start = 1'b0;
    n = 1;
    m = '0;
    while (o_res.done !== 1'b1 && o_res.abort !== 1'b1 && n < 12) begin
      if (o_mem.req === 1'b1) m = o_mem;
      @(posedge i_clock);
      #1;
      n++;
    end
    ofs = ins[25] ? of << ins[11:7] : {20'h0, ins[11:0]};
    bv = (ins[19:16] == LSU_PC_INDEX) ? 32'h0000_4008 : bs;
    nb = ins[23] ? bv + ofs : bv - ofs;
    ea = ins[24] ? nb : bv;
    w = {ea[31:2], 2'h0} ^ 32'h5A3C_96E1;
    st = !ins[20];
    sv = (ins[15:12] == LSU_PC_INDEX) ? 32'h0000_400C : sd;
    dv = (w >> (8 * ea[1:0])) | (w << (32 - 8 * ea[1:0]));
    if (ins[22]) dv = {24'h0, 8'(w >> (8 * (en ? 3 - ea[1:0] : ea[1:0])))};
    bwe = !flt && (!ins[24] || ins[21]) && !(!st && ins[15:12] == ins[19:16]);
    cmpv("addr", ea, m.addr);
    cmpv("write", 32'(st), 32'(m.write));
    cmpv("byte_sel", 32'(ins[22]), 32'(m.byte_sel));
    cmpv("user", 32'(!pv || (!ins[24] && ins[21])), 32'(m.user));
    cmpv("cyc", 32'(LSU_CYC_N), 32'(m.cyc));
    if (st) cmpv("wdata", ins[22] ? {4{sv[7:0]}} : sv, m.wdata);
    cmpv("abort", 32'(flt), 32'(o_res.abort));
    cmpv("load_we", 32'(!st && !flt), 32'(o_res.load_we));
    if (!st && !flt) cmpv("load_data", dv, o_res.load_data);
    if (!st && !flt) cmpv("load_reg", 32'(ins[15:12]), 32'(o_res.load_reg));
    cmpv("base_we", 32'(bwe), 32'(o_res.base_we));
    if (bwe) cmpv("base_data", nb, o_res.base_data);
    if (bwe) cmpv("base_reg", 32'(ins[19:16]), 32'(o_res.base_reg));
    if (!flt) cmpv("latency", st ? 4 : (ins[15:12] == 4'hF ? 8 : 5), n);
  endtask
  task automatic t_loads();
    for (int e = 0; e < 2; e++) begin
      for (int a = 0; a < 4; a++) begin
        xfer(mk(6'h19, 4'h2, 4'h1, 12'h024), 32'h2000 + a, 0, 0, 1'b1, e[0], 1'b0);
        xfer(mk(6'h1F, 4'h2, 4'h1, 12'hFFF), 32'h2000 + a, 0, 0, 1'b1, e[0], 1'b0);
        xfer(mk(6'h24, 4'h2, 4'h1, 12'h103), 32'h2100 + a, 32'h10, 32'h1A5, 1'b1, e[0], 1'b0);
      end
    end
  endtask
  task automatic t_stores();
    xfer(mk(6'h1A, 4'h2, 4'h1, 12'h002), 32'h3001, 0, 32'h8765_4321, 1'b1, 1'b1, 1'b0);
    xfer(mk(6'h18, 4'hF, 4'hF, 12'h010), 0, 0, 0, 1'b1, 1'b0, 1'b0);
  endtask
  task automatic t_user_pc();
    xfer(mk(6'h0B, 4'h2, 4'h1, 12'h008), 32'h5000, 0, 0, 1'b1, 1'b0, 1'b0);
    xfer(mk(6'h1B, 4'h2, 4'h1, 12'h008), 32'h5000, 0, 0, 1'b1, 1'b0, 1'b0);
    xfer(mk(6'h19, 4'h2, 4'h1, 12'h000), 32'h5000, 0, 0, 1'b0, 1'b0, 1'b0);
    xfer(mk(6'h19, 4'h2, 4'hF, 12'h004), 32'h5000, 0, 0, 1'b1, 1'b0, 1'b0);
  endtask
  task automatic t_fault();
    xfer(mk(6'h1B, 4'h2, 4'h1, 12'h004), 32'h6000, 0, 0, 1'b1, 1'b0, 1'b1);
    xfer(mk(6'h1A, 4'h2, 4'h1, 12'h004), 32'h6000, 0, 32'h55, 1'b1, 1'b0, 1'b1);
    xfer(mk(6'h19, 4'h2, 4'h1, 12'h004), 32'h6000, 0, 0, 1'b1, 1'b0, 1'b0);
  endtask
  initial begin
    i_nrst = 1'b0;
    i_start = 1'b0;
    i_req = '0;
    i_endian_select = 1'b0;
    fault_en = 1'b0;
    repeat (6) @(posedge i_clock);
    #1;
    i_nrst = 1'b1;
    t_loads();
    t_stores();
    t_user_pc();
    t_fault();
    give_verdict();
  end
endmodule
bind lsu_core lsu_asserts u_chk (.i_clock(i_clock), .i_nrst(i_nrst), .i_start(i_start), .i_req(i_req),
  .i_endian_select(i_endian_select), .i_rdata(i_rdata), .i_mem_fault(i_mem_fault),
  .o_busy(o_busy), .o_mem(o_mem), .o_res(o_res));
`default_nettype wire

// ---- verification/lsu_mem_model.sv ----
// Memory system model answering the load/store unit
`default_nettype none
module lsu_mem_model
  import lsu_pkg::*;
(
  input wire logic     i_clock,
  input wire logic     i_nrst,
  input wire lsu_mem_t i_mem,
  input wire logic     i_fault_en,
  output logic [31:0]  o_rdata,
  output logic         o_fault
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0]  hold;
  logic [31:0] word;
  logic        live;
  always_ff @(posedge i_clock) begin
    if (!i_nrst) hold <= 2'h0;
    else if (i_mem.req) hold <= 2'h2;
    else if (hold != 2'h0) hold <= hold - 2'h1;
  end
  assign word = {i_mem.addr[31:2], 2'h0} ^ 32'h5A3C_96E1;
  assign live = i_mem.req | (hold != 2'h0);
  // Outside the window the bus shows garbage, not the last word
  assign o_rdata = live ? word : ~word;
  assign o_fault = i_fault_en & live;
endmodule
`default_nettype wire
